// File: adc_host_end.sv
// Host controller: starts conversions, makes the serial clock by division
// and reads results into a two-entry buffer.
// Assumes one converter in chip-select mode or a chain of converters.
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_map.svh"

module adc_host_end (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    adc_link_if.host                   link,
    input  wire logic                  start_valid,
    input  wire logic                  start_daisy,
    output logic                       start_ready,
    output adc_link_pkg::result_t      word_data,
    output logic                       word_valid,
    input  wire logic                  word_ready
);
    import adc_link_pkg::*;

    localparam int BITS_CS    = `RESULT_BITS;
    localparam int BITS_DAISY = `RESULT_BITS * `CHAIN_WORDS;

    host_state_e state_r;
    logic [8:0]  wait_r;
    logic [8:0]  cyc_r;
    logic [4:0]  div_r;
    logic [5:0]  bits_r;
    logic        daisy_r;
    logic        cnv_r;
    logic        sclk_r;
    logic        sdi_r;
    logic [2:0]  sdo_s;
    logic        sdo_lvl_r;
    result_t     shift_r;
    result_t     mem_r [2];
    logic        wr_ptr_r;
    logic        rd_ptr_r;
    logic [1:0]  fill_r;
    logic        start_ready_r;
    logic        word_valid_r;
    result_t     word_data_r;

    wire         buf_in_ready = (fill_r != 2'd2);
    wire         div_end      = (div_r == 5'(`SCLK_HALF - 1));
    wire         last_bit     = (bits_r == 6'((daisy_r ? BITS_DAISY : BITS_CS) - 1));
    wire         word_bit     = (bits_r[3:0] == 4'hf);
    // Back-pressure: the edge that completes a word waits for buffer room
    wire         may_rise     = !(word_bit && !buf_in_ready);
    wire         do_rise      = (state_r == H_READ) && div_end && !sclk_r && may_rise;
    wire         do_fall      = (state_r == H_READ) && div_end && sclk_r;
    wire         push         = do_rise && word_bit;
    wire         pop          = word_valid && word_ready;
    wire         cycle_ok     = (cyc_r >= 9'(`CYC_CYCLES));
    wire  [1:0]  fill_nxt     = fill_r + 2'(push) - 2'(pop);
    wire         rd_ptr_nxt   = rd_ptr_r ^ pop;
    // Head is registered so the outputs come straight from flops
    wire         head_new     = push && (wr_ptr_r == rd_ptr_nxt);
    result_t     shift_nxt;
    result_t     head_nxt;

    assign shift_nxt   = {shift_r[`RESULT_MSB-1:0], sdo_lvl_r};
    assign start_ready = start_ready_r;
    assign head_nxt    = head_new ? shift_nxt : mem_r[rd_ptr_nxt];
    assign word_valid  = word_valid_r;
    assign word_data   = word_data_r;
    assign link.conversion_start           = cnv_r;
    assign link.serial_clk                 = sclk_r;
    assign link.serial_data_in_mode_select = sdi_r;

    // Data pin is foreign to this clock: three stages, accept on agreement
    always_ff @(posedge clk_sys) begin
        sdo_s <= {sdo_s[1:0], link.serial_data_out};
        if (rst) begin
            sdo_lvl_r <= 1'b1;
        end else if (sdo_s[2] == sdo_s[1]) begin
            sdo_lvl_r <= sdo_s[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r       <= H_IDLE;
            wait_r        <= '0;
            cyc_r         <= 9'(`CYC_CYCLES);
            div_r         <= '0;
            bits_r        <= '0;
            daisy_r       <= 1'b0;
            cnv_r         <= 1'b0;
            sclk_r        <= 1'b0;
            sdi_r         <= 1'b1;
            shift_r       <= '0;
            start_ready_r <= 1'b0;
        end else begin
            if (!cycle_ok) begin
                cyc_r <= cyc_r + 9'd1;
            end
            div_r <= (state_r == H_READ && !div_end) ? div_r + 5'd1 : '0;
            start_ready_r <= (state_r == H_IDLE) && cycle_ok && !(start_valid && start_ready_r);
            unique case (state_r)
                H_IDLE: begin
                    if (start_valid && start_ready_r) begin
                        daisy_r <= start_daisy;
                        sdi_r   <= !start_daisy;
                        cnv_r   <= 1'b0;
                        wait_r  <= 9'(`SETUP_CYCLES);
                        state_r <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (wait_r == 9'd0) begin
                        cnv_r   <= 1'b1;
                        cyc_r   <= '0;
                        state_r <= H_RISE;
                    end else begin
                        wait_r <= wait_r - 9'd1;
                    end
                end
                H_RISE: begin
                    // Mode level held across the edge before it may change
                    wait_r  <= 9'(`CONV_CYCLES);
                    state_r <= H_CONV;
                end
                H_CONV: begin
                    if (wait_r == 9'd0) begin
                        cnv_r   <= daisy_r;
                        bits_r  <= '0;
                        state_r <= H_READ;
                    end else begin
                        wait_r <= wait_r - 9'd1;
                    end
                end
                H_READ: begin
                    if (do_rise) begin
                        sclk_r  <= 1'b1;
                        shift_r <= shift_nxt;
                    end else if (do_fall) begin
                        sclk_r <= 1'b0;
                        bits_r <= bits_r + 6'd1;
                        if (last_bit) begin
                            cnv_r   <= 1'b0;
                            sdi_r   <= 1'b1;
                            state_r <= H_GAP;
                        end
                    end
                end
                H_GAP: begin
                    if (cycle_ok) begin
                        state_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // Two-entry result buffer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            fill_r   <= '0;
            word_valid_r <= 1'b0;
            word_data_r  <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= shift_nxt;
                wr_ptr_r        <= !wr_ptr_r;
            end
            rd_ptr_r     <= rd_ptr_nxt;
            fill_r       <= fill_nxt;
            word_valid_r <= (fill_nxt != 2'd0);
            word_data_r  <= head_nxt;
        end
    end
endmodule

`default_nettype wire

// File: adc_link_map.svh
// Constants of the converter link: widths, timing figures and cycle counts.
// Assumes a 200 MHz system clock on both ends.
`ifndef ADC_LINK_MAP_SVH
`define ADC_LINK_MAP_SVH

`define RESULT_BITS      16
`define RESULT_MSB       15
`define CLK_PERIOD_PS    5000
`define CONV_TIME_PS     1500000
`define CONV_CYCLES      (`CONV_TIME_PS / `CLK_PERIOD_PS)
`define ACQ_TIME_PS      500000
`define ACQ_CYCLES       ((`ACQ_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define THROUGHPUT_KSPS  500
`define CYCLE_TIME_PS    (1000000000 / `THROUGHPUT_KSPS)
`define CYC_CYCLES       ((`CYCLE_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SCLK_HALF        10
`define CHAIN_WORDS      2
`define EDGE_CNT_W       8
`define SETUP_CYCLES     2
`define SYNC_LAT         4

`endif

// File: adc_link_pkg.sv
// Types and helpers shared by both ends of the converter link.
// Assumes adc_link_map.svh for all figures.
`default_nettype none
`include "adc_link_map.svh"

package adc_link_pkg;
    typedef logic [`RESULT_MSB:0]    result_t;
    typedef logic [`EDGE_CNT_W-1:0]  edge_cnt_t;
    typedef enum logic {MODE_DAISY, MODE_CS} link_mode_e;
    typedef enum {H_IDLE, H_SETUP, H_RISE, H_CONV, H_READ, H_GAP} host_state_e;

    function automatic edge_cnt_t bin2gray(input edge_cnt_t b);
        bin2gray = b ^ (b >> 1);
    endfunction

    function automatic edge_cnt_t gray2bin(input edge_cnt_t g);
        edge_cnt_t b;
        b = g;
        for (int i = `EDGE_CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction
endpackage

`default_nettype wire

// File: adc_link_if.sv
// Pins between the host controller and the converter.
// The converter data pin is three-state; the wire level is resolved here.
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
    logic conversion_start;
    logic serial_clk;
    logic serial_data_in_mode_select;
    logic serial_data_out_drv;
    logic serial_data_out_oe_n;
    wire  serial_data_out;

    // Pull-up keeps the shared line defined while nobody drives it
    assign serial_data_out = serial_data_out_oe_n ? 1'b1 : serial_data_out_drv;

    modport device (
        input  conversion_start,
        input  serial_clk,
        input  serial_data_in_mode_select,
        output serial_data_out_drv,
        output serial_data_out_oe_n
    );

    modport host (
        output conversion_start,
        output serial_clk,
        output serial_data_in_mode_select,
        input  serial_data_out
    );
endinterface

`default_nettype wire

// File: adc_device_end.sv
// Contract
// - Each start rising edge begins conversion, fixes mode
// - Mode-select low at start edge: daisy chain
// - Mode-select high at start edge: chip select
// - Chip select: start low enables output
// - Chip select: either input low enables output
// - Daisy chain: host reads while start high
// - Daisy chain: data input feeds shift chain
// - Output changes only on serial clock falls; sdo_r also changes when a conversion starts or completes
// - Deselected clock edges do not advance output
// - Input low at completion enables busy indication
// - Sixteen-bit result from internal conversion clock
// - Host allows acquisition time between conversions
// - Readout shows the conversion just started
// - Host keeps start rate within throughput
// - Result shifts out most significant first
// - Result ready within maximum conversion time
//
// Converter end: internal conversion timer on clk_sys, falling-edge counter
// and chain register on the serial clock, output pin retimed on clk_sys.
// Assumes the serial clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_map.svh"

module adc_device_end (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    adc_link_if.device                 link,
    input  wire adc_link_pkg::result_t sample_code,
    output logic                       result_ready,
    output logic                       busy_armed,
    output logic                       mode_chip_select
);
    import adc_link_pkg::*;

    logic        link_clr_r;
    edge_cnt_t   edge_bin_r;
    edge_cnt_t   edge_gray_r;
    result_t     chain_r;
    edge_cnt_t   edge_nxt;

    logic [2:0]  cnv_s;
    logic [2:0]  sdi_s;
    logic [2:0]  chain_s;
    edge_cnt_t   gray_s [3];
    logic        cnv_lvl_r;
    logic        sdi_lvl_r;
    logic        chain_lvl_r;
    edge_cnt_t   gray_lvl_r;
    link_mode_e  mode_r;
    edge_cnt_t   base_r;
    logic        converting_r;
    logic [8:0]  conv_cnt_r;
    result_t     sample_r;
    result_t     result_r;
    logic        ready_r;
    logic        busy_r;
    logic        sdo_r;
    logic        oe_n_r;

    assign edge_nxt = edge_bin_r + 1'b1;

    // Link side is cleared asynchronously from a registered reset, so it needs no running serial clock
    always_ff @(posedge clk_sys) begin
        link_clr_r <= rst;
    end

    always_ff @(negedge link.serial_clk or posedge link_clr_r) begin
        if (link_clr_r) begin
            edge_bin_r  <= '0;
            edge_gray_r <= '0;
            chain_r     <= '0;
        end else begin
            edge_bin_r  <= edge_nxt;
            edge_gray_r <= bin2gray(edge_nxt);
            chain_r     <= {chain_r[`RESULT_MSB-1:0], link.serial_data_in_mode_select};
        end
    end

    // Pins and the edge count cross in three stages, taken once two agree
    always_ff @(posedge clk_sys) begin
        cnv_s     <= {cnv_s[1:0], link.conversion_start};
        sdi_s     <= {sdi_s[1:0], link.serial_data_in_mode_select};
        chain_s   <= {chain_s[1:0], chain_r[`RESULT_MSB]};
        gray_s[0] <= edge_gray_r;
        gray_s[1] <= gray_s[0];
        gray_s[2] <= gray_s[1];
        if (rst) begin
            cnv_lvl_r   <= 1'b0;
            sdi_lvl_r   <= 1'b1;
            chain_lvl_r <= 1'b0;
            gray_lvl_r  <= '0;
        end else begin
            if (cnv_s[2] == cnv_s[1]) cnv_lvl_r <= cnv_s[2];
            if (sdi_s[2] == sdi_s[1]) sdi_lvl_r <= sdi_s[2];
            if (chain_s[2] == chain_s[1]) chain_lvl_r <= chain_s[2];
            if (gray_s[2] == gray_s[1]) gray_lvl_r <= gray_s[2];
        end
    end

    wire        start_rise = (cnv_s[2] == cnv_s[1]) && cnv_s[2] && !cnv_lvl_r;
    wire        cs_mode    = (mode_r == MODE_CS);
    wire        either_low = !cnv_lvl_r || !sdi_lvl_r;
    wire        selected   = cs_mode ? either_low : cnv_lvl_r;
    wire        conv_done  = converting_r && (conv_cnt_r == 9'd0);
    edge_cnt_t  edge_now;
    edge_cnt_t  pos;
    assign      edge_now   = gray2bin(gray_lvl_r);
    assign      pos        = edge_now - base_r;
    wire        in_word    = (pos < edge_cnt_t'(`RESULT_BITS));
    wire [3:0]  bit_sel    = 4'(`RESULT_MSB) - pos[3:0];
    wire        data_bit   = in_word ? result_r[bit_sel] : chain_lvl_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_r       <= MODE_CS;
            base_r       <= '0;
            converting_r <= 1'b0;
            conv_cnt_r   <= '0;
            sample_r     <= '0;
            result_r     <= '0;
            ready_r      <= 1'b0;
            busy_r       <= 1'b0;
            sdo_r        <= 1'b0;
            oe_n_r       <= 1'b1;
        end else begin
            ready_r <= conv_done;
            if (start_rise) begin
                mode_r       <= sdi_lvl_r ? MODE_CS : MODE_DAISY;
                converting_r <= 1'b1;
                // Synchroniser delay comes off the count, so pin edge to result stays in time
                conv_cnt_r   <= 9'(`CONV_CYCLES - `SYNC_LAT - 1);
                sample_r     <= sample_code;
            end else if (conv_done) begin
                converting_r <= 1'b0;
                result_r     <= sample_r;
                busy_r       <= either_low;
            end else if (converting_r) begin
                conv_cnt_r <= conv_cnt_r - 9'd1;
            end
            // Edges seen while deselected are folded into the base
            if (!selected || start_rise) begin
                base_r <= edge_now;
            end
            // Busy shows high while converting, then the first data bit
            sdo_r  <= (converting_r && busy_r) ? 1'b1 : data_bit;
            oe_n_r <= !selected;
        end
    end

    assign link.serial_data_out_drv  = sdo_r;
    assign link.serial_data_out_oe_n = oe_n_r;
    assign result_ready              = ready_r;
    assign busy_armed                = busy_r;
    assign mode_chip_select          = (mode_r == MODE_CS);
endmodule

`default_nettype wire

// File: adc_link_sva.sv
// Checker for the pins between host end and converter end.
// Assumes instantiation beside the link interface, one clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_map.svh"

module adc_link_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic conversion_start,
    input wire logic serial_clk,
    input wire logic serial_data_in_mode_select,
    input wire logic serial_data_out_drv,
    input wire logic serial_data_out_oe_n,
    input wire logic serial_data_out
);
    localparam int CONV_N = `CONV_CYCLES;
    localparam int CYC_N  = `CYC_CYCLES;
    logic        start_d_r;
    logic        seen_r;
    logic        cs_r;
    logic [11:0] gap_r;
    logic [11:0] high_r;
    wire         rise_w = conversion_start && !start_d_r;
    wire         sat_g  = gap_r != 12'hfff;
    wire         sat_h  = high_r != 12'hfff;

    // Mode is tracked here from the pins, not taken from the converter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_d_r <= 1'b0;
            seen_r    <= 1'b0;
            cs_r      <= 1'b0;
            gap_r     <= 12'h000;
            high_r    <= 12'h000;
        end else begin
            start_d_r <= conversion_start;
            seen_r    <= seen_r || rise_w;
            cs_r      <= rise_w ? serial_data_in_mode_select : cs_r;
            gap_r     <= rise_w ? 12'h000 : gap_r + 12'(sat_g);
            high_r    <= rise_w ? 12'h000 : high_r + 12'(sat_h && conversion_start);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Eight cycles leave room for the three-stage synchroniser
    property p_cs_off;
        (seen_r && cs_r && conversion_start && serial_data_in_mode_select) [*8] |-> serial_data_out_oe_n;
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("output enabled while deselected");
    property p_cs_on;
        (seen_r && cs_r && !conversion_start) [*8] |-> !serial_data_out_oe_n;
    endproperty
    a_cs_on: assert property (p_cs_on) else $error("output not enabled in chip-select mode");
    property p_daisy_on;
        (seen_r && !cs_r && conversion_start) [*8] |-> !serial_data_out_oe_n;
    endproperty
    a_daisy_on: assert property (p_daisy_on) else $error("chain output not driven");
    property p_daisy_off;
        (seen_r && !cs_r && !conversion_start) [*8] |-> serial_data_out_oe_n;
    endproperty
    a_daisy_off: assert property (p_daisy_off) else $error("chain output driven while start low");
    // Reading before the conversion time would fetch a stale result
    property p_read_wait;
        serial_clk && seen_r |-> gap_r >= CONV_N;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("serial clock ran during conversion");
    property p_sclk_hold;
        serial_clk [*7] |-> $stable(serial_data_out_drv);
    endproperty
    a_sclk_hold: assert property (p_sclk_hold) else $error("data moved while serial clock high");
    property p_conv_wait;
        $fell(conversion_start) && seen_r |-> high_r >= CONV_N;
    endproperty
    a_conv_wait: assert property (p_conv_wait) else $error("start dropped before conversion end");
    property p_rate;
        rise_w && seen_r |-> gap_r >= CYC_N;
    endproperty
    a_rate: assert property (p_rate) else $error("conversions started too close");
    property p_mode_hold;
        rise_w |-> $past(serial_data_in_mode_select, 1) == serial_data_in_mode_select
            && $past(serial_data_in_mode_select, 2) == serial_data_in_mode_select;
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode level moved at start edge");
endmodule

`default_nettype wire

// File: tb_top.sv
// Testbench: host end and converter end joined by the link interface.
// Assumes both ends run from clk_sys; the host makes the serial clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import adc_link_pkg::*;
    logic    clk_sys     = 1'b0;
    logic    rst         = 1'b1;
    logic    start_valid = 1'b0;
    logic    start_daisy = 1'b0;
    logic    word_ready  = 1'b0;
    logic    stall       = 1'b0;
    result_t sample_code = 16'h0000;
    result_t word_data;
    logic    start_ready;
    logic    word_valid;
    logic    result_ready;
    logic    busy_armed;
    logic    mode_chip_select;
    int      failures    = 0;
    int      cmp_count   = 0;
    result_t exp_q[$];

    adc_link_if link_bus ();
    adc_host_end u_adc_host_end (.clk_sys(clk_sys), .rst(rst), .link(link_bus), .start_valid(start_valid),
        .start_daisy(start_daisy), .start_ready(start_ready), .word_data(word_data),
        .word_valid(word_valid), .word_ready(word_ready));
    adc_device_end u_adc_device_end (.clk_sys(clk_sys), .rst(rst), .link(link_bus), .sample_code(sample_code),
        .result_ready(result_ready), .busy_armed(busy_armed), .mode_chip_select(mode_chip_select));
    adc_link_sva u_adc_link_sva (.clk_sys(clk_sys), .rst(rst), .conversion_start(link_bus.conversion_start),
        .serial_clk(link_bus.serial_clk), .serial_data_in_mode_select(link_bus.serial_data_in_mode_select),
        .serial_data_out_drv(link_bus.serial_data_out_drv), .serial_data_out_oe_n(link_bus.serial_data_out_oe_n),
        .serial_data_out(link_bus.serial_data_out));

    always #2.5 clk_sys = ~clk_sys;

    task automatic check(input result_t seen, input result_t exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Random back-pressure; a stall holds it off for 600 cycles while one word waits in the buffer
    always @(negedge clk_sys) word_ready <= !stall && ($urandom % 4 != 0);

    always @(posedge clk_sys) begin
        if (!rst && word_valid === 1'b1 && word_ready === 1'b1) begin
            if (exp_q.size() == 0)
                check(result_t'(exp_q.size()), 16'h0001);
            else
                check(word_data, exp_q.pop_front());
        end
    end

    task automatic run_conv(input logic daisy, input logic hold);
        int n;
        @(negedge clk_sys);
        sample_code = result_t'($urandom);
        start_valid = 1'b1;
        start_daisy = daisy;
        stall       = hold;
        exp_q.push_back(sample_code);
        // The chain word after ours is the host's low mode-select level
        if (daisy)
            exp_q.push_back(16'h0000);
        n = 0;
        while (start_ready !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        check(result_t'(n < 3000), 16'h0001);
        @(negedge clk_sys);
        start_valid = 1'b0;
        n = 0;
        while (result_ready !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        // Start edge three cycles after acceptance, result within 300 cycles of it
        check(result_t'(n <= 304), 16'h0001);
        check(result_t'(mode_chip_select), result_t'(!daisy));
        check(result_t'(busy_armed), result_t'(daisy));
        if (hold) begin
            repeat (600) @(negedge clk_sys);
            check(result_t'(word_valid), 16'h0001);
            stall = 1'b0;
        end
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        check(result_t'(n < 3000), 16'h0001);
    endtask

    initial begin
        logic [5:0] daisy_tbl;
        daisy_tbl = 6'b110100;
        void'($urandom(32'hf08a7f61));
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            run_conv(daisy_tbl[i], i == 2);
        end
        check(result_t'(exp_q.size()), 16'h0000);
        end_of_test();
    end

    initial begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule

`default_nettype wire
